/* File: logic/bii_core.sv */
// instruction execution for irq enable, jumps, increment, software interrupt
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module bii_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic instr_valid,
  input wire logic [bii_pkg::BII_IW_W-1:0] instr_word,
  input wire logic [7:0] reg_rdata,
  output logic [bii_pkg::BII_RA_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic [bii_pkg::BII_PC_W-1:0] pc,
  output logic fetch_flush,
  output logic [bii_pkg::BII_PC_W-1:0] stack_push_data,
  output logic stack_push,
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic global_irq_enable,
  output logic illegal_op
);
  import bii_pkg::*;

  bii_state_t state_reg, state_next;
  logic [BII_PC_W-1:0] pc_reg, pc_next;
  logic [7:0] acc_reg, acc_next;
  logic z_reg, z_next;
  logic gie_reg, gie_next;
  logic flush_reg, flush_next;
  logic push_reg, push_next;
  logic [BII_PC_W-1:0] push_data_reg, push_data_next;
  logic [BII_RA_W-1:0] raddr_reg, raddr_next;
  logic [7:0] rwdata_reg, rwdata_next;
  logic rwe_reg, rwe_next;
  logic ill_reg, ill_next;
  logic [1:0] table_high_pointer;
  logic [1:0] pc_high_buffer;
  logic [3:0] opc;
  logic [7:0] inc_sum;
  logic [31:0] rd_stat;

  bii_ahb_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_stat(rd_stat),
    .rd_pc({22'h0, pc_reg}),
    .rd_acc({24'h000000, acc_reg}),
    .table_high_pointer(table_high_pointer),
    .pc_high_buffer(pc_high_buffer)
  );

  assign opc = instr_word[BII_IW_W-1:BII_OPC_LSB];
  assign inc_sum = reg_rdata + BII_ONE8;
  assign rd_stat = {21'h0, ill_reg, 6'h00, state_reg, z_reg, gie_reg};

  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    acc_next = acc_reg;
    z_next = z_reg;
    gie_next = gie_reg;
    flush_next = 1'b0;
    push_next = 1'b0;
    push_data_next = push_data_reg;
    raddr_next = instr_word[BII_RA_W-1:0];
    rwdata_next = rwdata_reg;
    rwe_next = 1'b0;
    ill_next = ill_reg;
    case (state_reg)
      BII_ST_EXEC: begin
        if (instr_valid) begin
          pc_next = pc_reg + BII_ONE10;
          case (opc)
            BII_OP_IRQ_OFF: gie_next = 1'b0;
            BII_OP_IRQ_ON: gie_next = 1'b1;
            BII_OP_JMP: begin
              if (instr_word[BII_ADR_W-1:0] == BII_ADR_LIMIT) begin
                ill_next = 1'b1;
              end else begin
                pc_next = {pc_high_buffer[1],
                           instr_word[BII_ADR_W-1:0]};
                flush_next = 1'b1;
                state_next = BII_ST_FLUSH;
              end
            end
            BII_OP_AJMP: begin
              pc_next = {table_high_pointer, acc_reg};
              flush_next = 1'b1;
              state_next = BII_ST_FLUSH;
            end
            BII_OP_INC: begin
              z_next = (inc_sum == 8'h00);
              if (instr_word[BII_DEST_BIT]) begin
                rwdata_next = inc_sum;
                rwe_next = 1'b1;
              end else begin
                acc_next = inc_sum;
              end
            end
            BII_OP_SWI: begin
              push_data_next = pc_reg + BII_ONE10;
              push_next = 1'b1;
              flush_next = 1'b1;
              state_next = BII_ST_SWI2;
            end
            BII_OP_NOP: ;
            default: ill_next = 1'b1;
          endcase
        end
      end
      BII_ST_SWI2: begin
        pc_next = BII_SWI_VECTOR;
        flush_next = 1'b1;
        state_next = BII_ST_FLUSH;
      end
      BII_ST_FLUSH: begin
        state_next = BII_ST_EXEC;
      end
      default: state_next = BII_ST_EXEC;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= BII_ST_EXEC;
      pc_reg <= BII_PC_RESET;
      acc_reg <= 8'h00;
      z_reg <= 1'b0;
      gie_reg <= BII_IRQ_EN_RESET;
      flush_reg <= 1'b0;
      push_reg <= 1'b0;
      push_data_reg <= 10'h000;
      raddr_reg <= 6'h00;
      rwdata_reg <= 8'h00;
      rwe_reg <= 1'b0;
      ill_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      acc_reg <= acc_next;
      z_reg <= z_next;
      gie_reg <= gie_next;
      flush_reg <= flush_next;
      push_reg <= push_next;
      push_data_reg <= push_data_next;
      raddr_reg <= raddr_next;
      rwdata_reg <= rwdata_next;
      rwe_reg <= rwe_next;
      ill_reg <= ill_next;
    end
  end

  // register read address is combinational so the increment sees data
  // in the same cycle; the write side is registered
  assign reg_addr = instr_word[BII_RA_W-1:0];
  assign reg_wdata = rwdata_reg;
  assign reg_we = rwe_reg;
  assign pc = pc_reg;
  assign fetch_flush = flush_reg;
  assign stack_push_data = push_data_reg;
  assign stack_push = push_reg;
  assign accumulator = acc_reg;
  assign zero_flag = z_reg;
  assign global_irq_enable = gie_reg;
  assign illegal_op = ill_reg;
endmodule

/* File: logic/bii_pkg.sv */
// package: opcodes, field layout and constants for the branch/irq/register_increment_op decoder
package bii_pkg;
  localparam int BII_PC_W = 10;
  localparam int BII_RA_W = 6;
  // instruction word width and field positions
  localparam int BII_IW_W = 13;
  localparam int BII_OPC_LSB = 9;
  localparam int BII_DEST_BIT = 6;
  localparam int BII_ADR_W = 9;
  localparam logic [9:0] BII_SWI_VECTOR = 10'h001;
  localparam logic [9:0] BII_PC_RESET = 10'h000;
  localparam logic [7:0] BII_ONE8 = 8'h01;
  localparam logic [9:0] BII_ONE10 = 10'h001;
  // upper bound (exclusive) for the direct jump field
  localparam logic [8:0] BII_ADR_LIMIT = 9'h1FF;
  localparam logic BII_IRQ_EN_RESET = 1'b0;
  localparam logic [31:0] BII_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] BII_ADDR_STAT = 32'h0000_0004;
  localparam logic [31:0] BII_ADDR_PC = 32'h0000_0008;
  localparam logic [31:0] BII_ADDR_ACC = 32'h0000_000C;
  // opcode field values (bits 12:9)
  localparam logic [3:0] BII_OP_NOP = 4'h0;
  localparam logic [3:0] BII_OP_IRQ_OFF = 4'h1;
  localparam logic [3:0] BII_OP_IRQ_ON = 4'h2;
  localparam logic [3:0] BII_OP_JMP = 4'h3;
  localparam logic [3:0] BII_OP_AJMP = 4'h4;
  localparam logic [3:0] BII_OP_INC = 4'h5;
  localparam logic [3:0] BII_OP_SWI = 4'h6;

  typedef enum logic [1:0] {
    BII_ST_EXEC = 2'b00,
    BII_ST_FLUSH = 2'b01,
    BII_ST_SWI2 = 2'b10
  } bii_state_t;
endpackage

/* File: logic/bii_ahb_regs.sv */
// ahb-lite slave: control register and status readback
`timescale 1ns/1ps
module bii_ahb_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [31:0] rd_stat,
  input wire logic [31:0] rd_pc,
  input wire logic [31:0] rd_acc,
  output logic [1:0] table_high_pointer,
  output logic [1:0] pc_high_buffer
);
  import bii_pkg::*;

  logic wr_pend_reg, wr_pend_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [3:0] ctrl_reg, ctrl_next;

  always_comb begin
    wr_pend_next = 1'b0;
    addr_next = addr_reg;
    ctrl_next = ctrl_reg;
    hrdata_next = hrdata_reg;
    // write lands in the data phase, one cycle after the address phase
    if (wr_pend_reg && addr_reg == BII_ADDR_CTRL) begin
      ctrl_next = hwdata[3:0];
    end
    if (hsel && htrans[1]) begin
      addr_next = haddr;
      wr_pend_next = hwrite;
      case (haddr)
        // forwarded so a read right behind a write sees the new value
        BII_ADDR_CTRL: hrdata_next = {28'h0000000, ctrl_next};
        BII_ADDR_STAT: hrdata_next = rd_stat;
        BII_ADDR_PC: hrdata_next = rd_pc;
        BII_ADDR_ACC: hrdata_next = rd_acc;
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      ctrl_reg <= 4'h0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign table_high_pointer = ctrl_reg[1:0];
  assign pc_high_buffer = ctrl_reg[3:2];
endmodule

/* File: verification/bii_core_props.sv */
// checker for the core's instruction side
`timescale 1ns/1ps
module bii_core_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic instr_valid,
  input wire logic [12:0] instr_word,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic [9:0] pc,
  input wire logic fetch_flush,
  input wire logic [9:0] stack_push_data,
  input wire logic stack_push,
  input wire logic [7:0] accumulator,
  input wire logic zero_flag,
  input wire logic global_irq_enable
);
  import bii_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic tk;
  logic [3:0] op;
  // flush cycles refuse words, so only these count as taken
  assign tk = instr_valid && !fetch_flush;
  assign op = instr_word[12:9];
  sequence s_push;
    stack_push && stack_push_data == $past(pc) + BII_ONE10;
  endsequence
  sequence s_vec;
    pc == BII_SWI_VECTOR && fetch_flush;
  endsequence
  property p_off;
    tk && op == BII_OP_IRQ_OFF |=> !global_irq_enable;
  endproperty
  a_off: assert property (p_off) else $error("enable stays");
  property p_on;
    tk && op == BII_OP_IRQ_ON
      |=> global_irq_enable && pc == $past(pc) + BII_ONE10;
  endproperty
  a_on: assert property (p_on) else $error("enable off");
  property p_jmp;
    tk && op == BII_OP_JMP && instr_word[8:0] != 9'h1FF
      |=> pc[8:0] == $past(instr_word[8:0]) && fetch_flush ##1 !fetch_flush;
  endproperty
  a_jmp: assert property (p_jmp) else $error("bad jump");
  property p_ajmp;
    tk && op == BII_OP_AJMP |=> pc[7:0] == $past(accumulator) && fetch_flush;
  endproperty
  a_ajmp: assert property (p_ajmp) else $error("bad acc jump");
  property p_inc;
    tk && op == BII_OP_INC && !instr_word[6]
      |=> accumulator == $past(reg_rdata) + BII_ONE8 && !reg_we;
  endproperty
  a_inc: assert property (p_inc) else $error("bad acc result");
  property p_wb;
    tk && op == BII_OP_INC && instr_word[6]
      |=> reg_we && reg_wdata == $past(reg_rdata) + BII_ONE8;
  endproperty
  a_wb: assert property (p_wb) else $error("bad write back");
  property p_zero;
    tk && op == BII_OP_INC |=> zero_flag == ($past(reg_rdata) == 8'hFF);
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero");
  property p_swi;
    tk && op == BII_OP_SWI |=> s_push ##1 s_vec ##1 !fetch_flush;
  endproperty
  a_swi: assert property (p_swi) else $error("bad swi");
endmodule
bind bii_core bii_core_props u_props (.hclk, .hresetn, .instr_valid,
  .instr_word, .reg_rdata, .reg_wdata, .reg_we, .pc, .fetch_flush,
  .stack_push_data, .stack_push, .accumulator, .zero_flag,
  .global_irq_enable);

/* File: verification/bii_fetch_model.sv */
// fetch unit, program memory and register file
`timescale 1ns/1ps
module bii_fetch_model (
  input wire logic hclk,
  input wire logic run,
  input wire logic [9:0] pc,
  input wire logic fetch_flush,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  output logic instr_valid,
  output logic [12:0] instr_word,
  output logic [7:0] reg_rdata
);
  logic [12:0] mem [0:1023];
  logic [7:0] rf [0:63];
  logic [5:0] wa;
  assign instr_valid = run && !fetch_flush;
  // idle word inverted so no stale opcode lingers
  assign instr_word = instr_valid ? mem[pc] : ~mem[pc];
  assign reg_rdata = rf[reg_addr];
  // write lands a cycle late, so address is kept
  always @(posedge hclk) begin
    wa <= reg_addr;
    if (reg_we) rf[wa] <= reg_wdata;
  end
  initial for (int i = 0; i < 1024; i++) mem[i] = '0;
endmodule

/* File: verification/branch_interrupt_register_increment_op_instructions_test.sv */
// bench for the branch, irq and increment core
`timescale 1ns/1ps
module branch_interrupt_register_increment_op_instructions_test;
  import bii_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic run = 1'b0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic hreadyout, hresp, instr_valid, reg_we, fetch_flush, stack_push;
  logic zero_flag, global_irq_enable, illegal_op;
  logic [12:0] instr_word;
  logic [7:0] reg_rdata, reg_wdata, accumulator;
  logic [5:0] reg_addr;
  logic [9:0] pc, stack_push_data, epc = '0;
  int errors = 0, n_checks = 0;
  always #2 hclk = ~hclk;
  bii_core u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hrdata, .hreadyout, .hresp, .instr_valid, .instr_word,
    .reg_rdata, .reg_addr, .reg_wdata, .reg_we, .pc, .fetch_flush,
    .stack_push_data, .stack_push, .accumulator, .zero_flag,
    .global_irq_enable, .illegal_op);
  bii_fetch_model u_fm (.hclk, .run, .pc, .fetch_flush, .reg_addr,
    .reg_wdata, .reg_we, .instr_valid, .instr_word, .reg_rdata);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task step(input logic [12:0] w);
    @(posedge hclk);
    u_fm.mem[epc] = w;
    run <= 1'b1;
    @(posedge hclk);
    run <= 1'b0;
    #1;
  endtask
  task t_irq;
    step({BII_OP_IRQ_ON, 9'h000});
    epc++;
    chk(global_irq_enable, 1'b1);
    step({BII_OP_IRQ_OFF, 9'h000});
    epc++;
    chk({global_irq_enable, pc}, {1'b0, epc});
    step({BII_OP_NOP, 9'h000});
    epc++;
    chk({global_irq_enable, pc}, {1'b0, epc});
    $display("t_irq done");
  endtask
  task t_inc;
    u_fm.rf[5] = 8'hFF;
    u_fm.rf[63] = 8'h7F;
    step({BII_OP_INC, 3'h0, 6'h05});
    epc++;
    chk({accumulator, zero_flag}, {8'h00, 1'b1});
    step({BII_OP_INC, 3'h1, 6'h3F});
    epc++;
    @(posedge hclk);
    #1;
    chk({u_fm.rf[63], u_fm.rf[5], zero_flag}, {16'h80FF, 1'b0});
    $display("t_inc done");
  endtask
  task t_jmp;
    ahb(1'b1, BII_ADDR_CTRL, 32'h0000_000A);
    step({BII_OP_JMP, 9'h1FE});
    epc = 10'h3FE;
    chk({fetch_flush, pc}, {1'b1, epc});
    step({BII_OP_INC, 3'h0, 6'h3F});
    epc++;
    step({BII_OP_AJMP, 9'h000});
    epc = 10'h281;
    chk({fetch_flush, pc}, {1'b1, epc});
    step({BII_OP_JMP, 9'h1FF});
    epc++;
    chk({illegal_op, pc}, {1'b1, epc});
    $display("t_jmp done");
  endtask
  task t_swi;
    step({BII_OP_SWI, 9'h000});
    chk({stack_push, stack_push_data}, {1'b1, epc + BII_ONE10});
    @(posedge hclk);
    #1;
    epc = BII_SWI_VECTOR;
    chk(pc, epc);
    ahb(1'b0, BII_ADDR_STAT, '0);
    chk(rd & 32'h0000_040F, 32'h0000_0400);
    ahb(1'b0, BII_ADDR_ACC, '0);
    chk(rd[7:0], 8'h81);
    ahb(1'b0, 32'h0000_0010, '0);
    chk(rd, 32'h0000_0000);
    ahb(1'b0, BII_ADDR_PC, '0);
    chk(rd, {22'h0, BII_SWI_VECTOR});
    ahb(1'b0, BII_ADDR_CTRL, '0);
    chk(rd, 32'h0000_000A);
    chk(hresp, 1'b0);
    $display("t_swi done");
  endtask
  task conclude;
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_irq;
    t_inc;
    t_jmp;
    t_swi;
    conclude;
  end
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    errors++;
    conclude;
  end
endmodule
